// *** csd_pkg.sv ***
// constants for the charger status-detail register bank
// assumes a byte-wide register read/write port driven by the control-port front end
// Contract
// - input supply detail bits 6:5 read 00 below undervoltage, 10 above overvoltage, 11 valid, never 01.
// - reverse output detail bits 4:3 read 00 below undervoltage and 10 above overvoltage.
// - reverse output detail reads 01 while current limiting occurred within the last 37.5 ms.
// - reverse output detail reads 11 when reverse mode is disabled or the output is healthy.
// - bit 0 of the first register shows the real battery-to-system switch state.
// - bit 7 of the second register shows the thermal regulation flag.
// - the first register is read-only, its spare bits read zero and it resets to zero.
// - battery detail reports overcurrent, then missing, then overvoltage, then timer fault, then below prequal.
package csd_pkg;
  localparam logic [7:0] CSD_OFS_FIRST = 8'h13;
  localparam logic [7:0] CSD_OFS_SECOND = 8'h14;
  localparam logic [7:0] CSD_RST_FIRST = 8'h00;
  localparam logic [7:0] CSD_RST_SECOND = 8'hf8;
  localparam int CSD_IN_POS = 5;
  localparam int CSD_REV_POS = 3;
  localparam int CSD_BSW_POS = 0;
  localparam int CSD_THERMAL_REGULATION_FLAG_POS = 7;
  localparam int CSD_BAT_POS = 4;
  localparam logic [3:0] CSD_MODE_REVERSE = 4'ha;
  localparam logic [1:0] CSD_IN_UNDER = 2'h0;
  localparam logic [1:0] CSD_IN_OVER = 2'h2;
  localparam logic [1:0] CSD_IN_VALID = 2'h3;
  localparam logic [1:0] CSD_REV_UNDER = 2'h0;
  localparam logic [1:0] CSD_REV_ILIM = 2'h1;
  localparam logic [1:0] CSD_REV_OVER = 2'h2;
  localparam logic [1:0] CSD_REV_OK = 2'h3;
  localparam logic [2:0] CSD_BAT_MISSING = 3'h0;
  localparam logic [2:0] CSD_BAT_PREQUAL = 3'h1;
  localparam logic [2:0] CSD_BAT_TIMER = 3'h2;
  localparam logic [2:0] CSD_BAT_OK = 3'h3;
  localparam logic [2:0] CSD_BAT_LOW = 3'h4;
  localparam logic [2:0] CSD_BAT_OVERV = 3'h5;
  localparam logic [2:0] CSD_BAT_OVERC = 3'h6;
  localparam logic [2:0] CSD_BAT_NA = 3'h7;
  localparam real CSD_CLK_MHZ = 20.0;
  localparam real CSD_ILIM_HOLD_MS = 37.5;
  // longest time: round down
  localparam int CSD_ILIM_HOLD_CYC = int'($floor(CSD_ILIM_HOLD_MS * 1000.0 * CSD_CLK_MHZ));
  localparam int CSD_HOLD_W = 20;
endpackage

// *** csd_regs.sv ***
// charger status-detail registers, first and second detail bytes
// assumes analog comparator flags arrive asynchronously; the read port is on clk_sys_in
`timescale 1ns/1ns
`default_nettype none
module csd_regs
  import csd_pkg::*;
#(
  parameter int HOLD_CYC = CSD_ILIM_HOLD_CYC
)
(
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  input wire logic clk_en_in,
  input wire logic in_under_in,
  input wire logic in_over_in,
  input wire logic rev_under_in,
  input wire logic rev_over_in,
  input wire logic rev_ilim_in,
  input wire logic rev_enable_pin_in,
  input wire logic [3:0] mode_in,
  input wire logic batt_switch_on_in,
  input wire logic temp_over_in,
  input wire logic bat_overcurrent_in,
  input wire logic bat_missing_in,
  input wire logic bat_overvoltage_in,
  input wire logic bat_timer_fault_in,
  input wire logic bat_prequal_in,
  input wire logic bat_low_in,
  input wire logic bat_na_in,
  input wire logic [3:0] charge_detail_in,
  input wire logic rd_en_in,
  input wire logic wr_en_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  output logic [7:0] rdata_out,
  output logic rvalid_out
);
  localparam int NS = 16;

  typedef struct packed {
    logic [NS-1:0] s1;
    logic [NS-1:0] s2;
    logic [CSD_HOLD_W-1:0] hold;
    logic [7:0] first;
    logic [7:0] second;
    logic [7:0] rdata;
    logic rvalid;
  } csd_state_s;

  csd_state_s st_q;
  csd_state_s st_d;
  logic [NS-1:0] raw;

  assign raw = {bat_na_in, bat_low_in, bat_prequal_in, bat_timer_fault_in, bat_overvoltage_in,
                bat_missing_in, bat_overcurrent_in, temp_over_in, batt_switch_on_in,
                rev_enable_pin_in, rev_ilim_in, rev_over_in, rev_under_in, in_over_in,
                in_under_in, 1'b0};

  function automatic logic [2:0] bat_pick(input logic [NS-1:0] s);
    if (s[9]) return CSD_BAT_OVERC;
    else if (s[10]) return CSD_BAT_MISSING;
    else if (s[11]) return CSD_BAT_OVERV;
    else if (s[12]) return CSD_BAT_TIMER;
    else if (s[13]) return CSD_BAT_PREQUAL;
    else if (s[14]) return CSD_BAT_LOW;
    else if (s[15]) return CSD_BAT_NA;
    else return CSD_BAT_OK;
  endfunction

  logic in_under_s, in_over_s, rev_under_s, rev_over_s, rev_ilim_s, rev_en_s;
  logic rev_active;
  logic [1:0] in_code, rev_code;
  assign in_under_s = st_q.s2[1];
  assign in_over_s = st_q.s2[2];
  assign rev_under_s = st_q.s2[3];
  assign rev_over_s = st_q.s2[4];
  assign rev_ilim_s = st_q.s2[5];
  assign rev_en_s = st_q.s2[6];
  // mode comes from on-clock logic, so it is not synchronised
  assign rev_active = rev_en_s || (mode_in == CSD_MODE_REVERSE);

  always_comb
  begin
    // input supply code, 01 never produced
    if (in_under_s)
      in_code = CSD_IN_UNDER;
    else if (in_over_s)
      in_code = CSD_IN_OVER;
    else
      in_code = CSD_IN_VALID;
    if (!rev_active)
      rev_code = CSD_REV_OK;
    else if (rev_under_s)
      rev_code = CSD_REV_UNDER;
    else if (rev_over_s)
      rev_code = CSD_REV_OVER;
    // current limit seen within the hold window
    else if (rev_ilim_s || st_q.hold != '0)
      rev_code = CSD_REV_ILIM;
    else
      rev_code = CSD_REV_OK;
  end

  always_comb
  begin
    st_d = st_q;
    st_d.s1 = raw;
    st_d.s2 = st_q.s1;
    if (rev_active && rev_ilim_s)
      st_d.hold = CSD_HOLD_W'(HOLD_CYC);
    else if (st_q.hold != '0)
      st_d.hold = st_q.hold - 1'b1;
    st_d.first = 8'h00;
    st_d.first[CSD_IN_POS +: 2] = in_code;
    st_d.first[CSD_REV_POS +: 2] = rev_code;
    st_d.first[CSD_BSW_POS] = st_q.s2[7];
    st_d.second[CSD_THERMAL_REGULATION_FLAG_POS] = st_q.s2[8];
    st_d.second[CSD_BAT_POS +: 3] = bat_pick(st_q.s2);
    st_d.second[3:0] = charge_detail_in;
    st_d.rvalid = rd_en_in;
    // writes are not decoded at all
    if (rd_en_in)
    begin
      if (addr_in == CSD_OFS_FIRST)
        st_d.rdata = st_q.first;
      else if (addr_in == CSD_OFS_SECOND)
        st_d.rdata = st_q.second;
      else
        st_d.rdata = 8'h00;
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (sys_rst_in)
    begin
      st_q <= '0;
      st_q.first <= CSD_RST_FIRST;
      st_q.second <= CSD_RST_SECOND;
    end
    else if (clk_en_in)
      st_q <= st_d;
  end

  assign rdata_out = st_q.rdata;
  assign rvalid_out = st_q.rvalid;

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (sys_rst_in);

  // a read request taken at an enabled edge
  sequence read_first_s;
    clk_en_in && rd_en_in && addr_in == CSD_OFS_FIRST;
  endsequence

  sequence read_second_s;
    clk_en_in && rd_en_in && addr_in == CSD_OFS_SECOND;
  endsequence

  // current limit seen while reverse operation is on
  sequence ilim_seen_s;
    clk_en_in && rev_active && rev_ilim_s;
  endsequence

  // reverse output inside both voltage limits
  sequence rev_clean_s;
    clk_en_in && rev_active && !rev_under_s && !rev_over_s;
  endsequence

  in_code_legal_a: assert property (st_q.first[6:5] != 2'h1) else $error("input detail reserved code");
  in_under_code_a: assert property (clk_en_in && in_under_s |=> st_q.first[6:5] == CSD_IN_UNDER)
    else $error("undervoltage input code wrong");
  rev_over_code_a: assert property (clk_en_in && rev_active && !rev_under_s && rev_over_s |=>
    st_q.first[4:3] == CSD_REV_OVER) else $error("reverse overvoltage code wrong");
  rev_hold_a: assert property (ilim_seen_s ##1 rev_clean_s |=> st_q.first[4:3] == CSD_REV_ILIM)
    else $error("limit hold lost");
  rev_off_a: assert property (clk_en_in && !rev_active |=> st_q.first[4:3] == CSD_REV_OK)
    else $error("disabled reverse code wrong");
  switch_mirror_a: assert property (clk_en_in |=> st_q.first[0] == $past(st_q.s2[7]))
    else $error("switch state not mirrored");
  thermal_regulation_flag_mirror_a: assert property (clk_en_in |=> st_q.second[7] == $past(st_q.s2[8]))
    else $error("thermal flag not mirrored");
  spare_zero_a: assert property (st_q.first[7] == 1'b0 && st_q.first[2:1] == 2'h0)
    else $error("spare bits not zero");
  bat_prio_a: assert property (clk_en_in && st_q.s2[9] |=> st_q.second[6:4] == CSD_BAT_OVERC)
    else $error("overcurrent not first");
  write_ignored_a: assert property (clk_en_in && wr_en_in && !rd_en_in |=> $stable(st_q.rdata))
    else $error("write changed read data");

  in_over_code_a: assert property (clk_en_in && !in_under_s && in_over_s |=> st_q.first[6:5] == CSD_IN_OVER)
    else $error("overvoltage input code wrong");
  in_valid_code_a: assert property (clk_en_in && !in_under_s && !in_over_s |=> st_q.first[6:5] == CSD_IN_VALID)
    else $error("valid input code wrong");
  rev_under_code_a: assert property (clk_en_in && rev_active && rev_under_s |=> st_q.first[4:3] == CSD_REV_UNDER)
    else $error("reverse undervoltage code wrong");
  rev_ok_code_a: assert property (clk_en_in && rev_active && !rev_under_s && !rev_over_s && !rev_ilim_s &&
    st_q.hold == '0 |=> st_q.first[4:3] == CSD_REV_OK) else $error("healthy reverse code wrong");

  // the hold window restarts on every limit event seen while reverse operation is on and then runs down
  hold_load_a: assert property (ilim_seen_s |=> st_q.hold == CSD_HOLD_W'(HOLD_CYC))
    else $error("limit hold not loaded");
  hold_count_a: assert property (clk_en_in && !(rev_active && rev_ilim_s) && st_q.hold != '0 |=>
    st_q.hold == $past(st_q.hold) - 1) else $error("limit hold not counting");

  bat_missing_a: assert property (clk_en_in && !st_q.s2[9] && st_q.s2[10] |=> st_q.second[6:4] == CSD_BAT_MISSING)
    else $error("missing battery not second");
  bat_overv_a: assert property (clk_en_in && !st_q.s2[9] && !st_q.s2[10] && st_q.s2[11] |=>
    st_q.second[6:4] == CSD_BAT_OVERV) else $error("battery overvoltage not third");

  // read port answers one cycle later with the byte as it stood at the request
  read_first_a: assert property (read_first_s |=> rvalid_out && rdata_out == $past(st_q.first))
    else $error("first register read wrong");
  read_second_a: assert property (read_second_s |=> rvalid_out && rdata_out == $past(st_q.second))
    else $error("second register read wrong");
  read_unmapped_a: assert property (clk_en_in && rd_en_in && addr_in != CSD_OFS_FIRST &&
    addr_in != CSD_OFS_SECOND |=> rdata_out == 8'h00) else $error("unmapped read not zero");
  read_pulse_a: assert property (clk_en_in && !rd_en_in |=> !rvalid_out)
    else $error("read valid without request");

  // a low enable must freeze the synchronisers and the hold counter too
  freeze_hold_a: assert property (!clk_en_in |=> $stable(st_q))
    else $error("state moved while disabled");
endmodule
`default_nettype wire

// *** csd_host.sv ***
// host model: issues single register reads and writes on the byte port
// assumes the bench calls access() and clk_sys_in runs freely
`timescale 1ns/1ns
`default_nettype none
module csd_host (
  input wire logic clk_sys_in,
  output logic rd_en_out,
  output logic wr_en_out,
  output logic [7:0] addr_out,
  output logic [7:0] wdata_out
);
  initial
  begin
    rd_en_out = 1'b0;
    wr_en_out = 1'b0;
    addr_out = 8'h00;
    wdata_out = 8'h00;
  end
  // between accesses the bus shows the inverse, never the last value
  task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys_in);
    rd_en_out = !wr;
    wr_en_out = wr;
    addr_out = a;
    wdata_out = d;
    @(negedge clk_sys_in);
    rd_en_out = 1'b0;
    wr_en_out = 1'b0;
    addr_out = ~a;
    wdata_out = ~d;
  endtask
endmodule
`default_nettype wire

// *** csd_regs_bench.sv ***
// self-checking bench for the status-detail registers
// assumes csd_pkg, csd_regs and csd_host are compiled first
`timescale 1ns/1ns
`default_nettype none
module csd_regs_bench;
  import csd_pkg::*;
  localparam int HOLD = 20;
  logic clk_sys_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic clk_en = 1'b1;
  logic rd_en, wr_en, rvalid;
  logic [7:0] addr, wdata, rdata;
  logic [31:0] r = 32'd51046;
  logic [22:0] v = 23'h440025;
  logic [7:0] q[$];
  int mismatches = 0;
  int n_tests = 0;
  csd_host csd_host_inst (.clk_sys_in(clk_sys_in), .rd_en_out(rd_en), .wr_en_out(wr_en), .addr_out(addr),
    .wdata_out(wdata));
  csd_regs #(.HOLD_CYC(HOLD)) csd_regs_inst (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .clk_en_in(clk_en),
    .in_under_in(v[0]), .in_over_in(v[1]), .rev_under_in(v[2]), .rev_over_in(v[3]), .rev_ilim_in(v[4]),
    .rev_enable_pin_in(v[5]), .mode_in(v[9:6]), .batt_switch_on_in(v[10]), .temp_over_in(v[11]),
    .bat_overcurrent_in(v[12]), .bat_missing_in(v[13]), .bat_overvoltage_in(v[14]), .bat_timer_fault_in(v[15]),
    .bat_prequal_in(v[16]), .bat_low_in(v[17]), .bat_na_in(v[18]), .charge_detail_in(v[22:19]),
    .rd_en_in(rd_en), .wr_en_in(wr_en), .addr_in(addr), .wdata_in(wdata), .rdata_out(rdata), .rvalid_out(rvalid));
  initial
  begin
    forever #25 clk_sys_in = ~clk_sys_in;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    for (int i = 0; i < 32; i++)
      x = x[0] ? (x >> 1) ^ 32'h80200003 : x >> 1;
    return x;
  endfunction
  function automatic logic [7:0] e_first(input logic [22:0] x);
    logic [1:0] i;
    logic [1:0] o;
    i = x[0] ? CSD_IN_UNDER : x[1] ? CSD_IN_OVER : CSD_IN_VALID;
    o = !(x[5] || x[9:6] == CSD_MODE_REVERSE) ? CSD_REV_OK : x[2] ? CSD_REV_UNDER : x[3] ? CSD_REV_OVER : CSD_REV_OK;
    return {1'b0, i, o, 2'b00, x[10]};
  endfunction
  function automatic logic [7:0] e_second(input logic [22:0] x);
    logic [2:0] b;
    b = x[12] ? CSD_BAT_OVERC : x[13] ? CSD_BAT_MISSING : x[14] ? CSD_BAT_OVERV : x[15] ? CSD_BAT_TIMER :
      x[16] ? CSD_BAT_PREQUAL : x[17] ? CSD_BAT_LOW : x[18] ? CSD_BAT_NA : CSD_BAT_OK;
    return {x[11], b, x[22:19]};
  endfunction
  task automatic chk(input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e)
    begin
      mismatches++;
      $display("wrong value rdata expected %h seen %h", e, g);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    q.push_back(e);
    csd_host_inst.access(1'b0, a, r[7:0]);
  endtask
  task automatic close_out;
    // a read that never answered is a failure too
    if (q.size() != 0)
      mismatches++;
    $display("mismatches %0d n_tests %0d", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  always @(negedge clk_sys_in)
    if (rvalid === 1'b1)
    begin
      if (q.size() == 0)
        chk(8'h00, ~rdata);
      else
        chk(q.pop_front(), rdata);
    end
  initial
  begin
    // status is rebuilt one edge after release, so each reset value is read at the release edge
    repeat (9) @(negedge clk_sys_in);
    fork
      rd(CSD_OFS_FIRST, CSD_RST_FIRST);
      begin
        @(negedge clk_sys_in);
        sys_rst_in = 1'b0;
      end
    join
    sys_rst_in = 1'b1;
    repeat (3) @(negedge clk_sys_in);
    fork
      rd(CSD_OFS_SECOND, CSD_RST_SECOND);
      begin
        @(negedge clk_sys_in);
        sys_rst_in = 1'b0;
      end
    join
    repeat (40)
    begin
      r = lfsr(r);
      v = {r[31:28], r[27:21] & r[20:14], r[13:12], r[11] ? CSD_MODE_REVERSE : r[10:7], r[6], 1'b0, r[5:2]};
      // freeze only after the last answer has dropped, or its valid pulse would be held
      @(negedge clk_sys_in);
      clk_en = 1'b0;
      repeat (3) @(negedge clk_sys_in);
      clk_en = 1'b1;
      repeat (5) @(negedge clk_sys_in);
      rd(CSD_OFS_FIRST, e_first(v));
      rd(CSD_OFS_SECOND, e_second(v));
      csd_host_inst.access(1'b1, r[0] ? CSD_OFS_FIRST : CSD_OFS_SECOND, r[31:24]);
      rd(r[0] ? CSD_OFS_FIRST : CSD_OFS_SECOND, r[0] ? e_first(v) : e_second(v));
      rd(r[1] ? 8'h12 : 8'h15, 8'h00);
    end
    v = 23'h440031;
    @(negedge clk_sys_in);
    v[4] = 1'b0;
    repeat (4) @(negedge clk_sys_in);
    rd(CSD_OFS_FIRST, 8'h08);
    repeat (HOLD + 5) @(negedge clk_sys_in);
    rd(CSD_OFS_FIRST, 8'h18);
    repeat (3) @(negedge clk_sys_in);
    close_out();
  end
  // span is several times the expected run length
  initial
  begin
    repeat (5000) @(posedge clk_sys_in);
    mismatches++;
    close_out();
  end
endmodule
`default_nettype wire
